// ==== src/compare_unit_pkg.sv ====
// Package with constants, types and encodings of the compare, skip and branch unit.
package compare_unit_pkg;
   localparam int DATA_WIDTH = 16;
   localparam int HALF_BIT   = 4;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [3:0] BASE_CYCLES  = 4'h1;
   localparam logic [3:0] SKIP1_CYCLES = 4'h2;
   localparam logic [3:0] SKIP2_CYCLES = 4'h3;
   localparam logic [3:0] TAKEN_CYCLES = 4'h5;
   localparam logic [3:0] SFR_EXTRA    = 4'h1;

   // Wishbone register byte offsets.
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_COUNT  = 4'h8;
   localparam int CTRL_SFR_EN_BIT = 0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   typedef enum logic [3:0] {
      compare_op,
      compare_zero_op,
      compare_borrow_op,
      skip_on_equal_op,
      branch_on_equal_op,
      skip_on_greater_op,
      branch_on_greater_op,
      skip_on_less_op,
      branch_on_less_op,
      skip_on_unequal_op,
      branch_on_unequal_op,
      idle_op
   } op_type;

   typedef enum logic [1:0] {
      src_register,
      src_accumulator,
      src_literal
   } source_type;

   typedef struct packed {
      logic carry;
      logic half_carry_flag;
      logic negative;
      logic signed_wrap_flag;
      logic zero;
   } flags_type;

   typedef struct packed {
      logic                  valid;
      op_type                op;
      source_type            source;
      logic [DATA_WIDTH-1:0] base_operand_reg;
      logic [DATA_WIDTH-1:0] source_operand_reg;
      logic [DATA_WIDTH-1:0] working_accumulator;
      logic [7:0]            literal;
      logic                  peripheral_operand;
      logic                  next_is_two_word;
   } request_type;

   typedef struct packed {
      logic      flags_write;
      flags_type flags;
      logic      skip;
      logic      branch;
      logic [3:0] cycles;
   } result_type;
endpackage

// ==== src/compare_subtractor.sv ====
// Subtractor forming base minus operand minus borrow with the five arithmetic flags.
`timescale 1ns/1ps
module compare_subtractor
   import compare_unit_pkg::*;
#(
   parameter int WIDTH = DATA_WIDTH
) (
   input  wire logic [WIDTH-1:0] minuend,    // Left operand.
   input  wire logic [WIDTH-1:0] subtrahend, // Right operand.
   input  wire logic             carry_in,   // One means no borrow.
   output flags_type             flags       // Resulting flags.
);
   logic [WIDTH:0]    full;
   logic [HALF_BIT:0] low;
   logic [WIDTH-1:0]  diff;

   // Borrow is the complement of carry, so carry set adds the inverted operand plus one.
   always_comb begin
      full = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, carry_in};
      low  = {1'b0, minuend[HALF_BIT-1:0]} + {1'b0, ~subtrahend[HALF_BIT-1:0]}
             + {{HALF_BIT{1'b0}}, carry_in};
      diff = full[WIDTH-1:0];
      flags.carry            = full[WIDTH];
      flags.half_carry_flag  = low[HALF_BIT];
      flags.negative         = diff[WIDTH-1];
      flags.signed_wrap_flag = (minuend[WIDTH-1] != subtrahend[WIDTH-1])
                               && (diff[WIDTH-1] != minuend[WIDTH-1]);
      flags.zero             = (diff == ZERO_WORD);
   end
endmodule

// ==== src/compare_skip_branch_unit.sv ====
// Compare, skip and branch unit with a classic Wishbone slave for control and status.
`timescale 1ns/1ps
module compare_skip_branch_unit
   import compare_unit_pkg::*;
(
   input  wire logic        mclk,      // Core clock, 200 MHz.
   input  wire logic        rst,       // Asynchronous reset, active high.
   input  request_type      req,       // Decoded instruction from the pipeline.
   input  wire logic        carry_now, // Current carry flag.
   output result_type       result,    // Registered decision and flags.
   input  wire logic        wb_cyc_i,  // Wishbone cycle.
   input  wire logic        wb_stb_i,  // Wishbone strobe.
   input  wire logic        wb_we_i,   // Wishbone write enable.
   input  wire logic [3:0]  wb_adr_i,  // Wishbone byte address.
   input  wire logic [3:0]  wb_sel_i,  // Wishbone byte selects.
   input  wire logic [31:0] wb_dat_i,  // Wishbone write data.
   output logic      [31:0] wb_dat_o,  // Wishbone read data.
   output logic             wb_ack_o   // Wishbone acknowledge.
);
   logic [DATA_WIDTH-1:0] left;
   logic [DATA_WIDTH-1:0] right;
   logic                  carry_in;
   flags_type             sub_flags;
   result_type            next_result;
   logic                  sfr_penalty_en;
   logic [15:0]           op_count;
   flags_type             last_flags;
   logic                  cond;
   logic                  is_skip;
   logic                  is_branch;
   logic                  wb_hit;

   function automatic logic [3:0] skip_cost(input logic two_word);
      skip_cost = two_word ? SKIP2_CYCLES : SKIP1_CYCLES;
   endfunction

   // Operand selection for the subtractor.
   always_comb begin
      left     = req.base_operand_reg;
      right    = req.source_operand_reg;
      carry_in = 1'b1;
      unique case (req.op)
         compare_op: begin
            if (req.source == src_accumulator) begin
               right = req.working_accumulator;
            end else if (req.source == src_literal) begin
               right = {8'h00, req.literal};
            end
         end
         compare_zero_op: begin
            right = ZERO_WORD;
         end
         compare_borrow_op: begin
            carry_in = carry_now;
            if (req.source == src_accumulator) begin
               right = req.working_accumulator;
            end else if (req.source == src_literal) begin
               right = {8'h00, req.literal};
            end
         end
         default: begin
            right = req.source_operand_reg;
         end
      endcase
   end

   compare_subtractor #(
      .WIDTH(DATA_WIDTH)
   ) u_sub (
      .minuend   (left),
      .subtrahend(right),
      .carry_in  (carry_in),
      .flags     (sub_flags)
   );

   // Signed comparisons for greater and less, as the registers hold signed words.
   always_comb begin
      cond      = 1'b0;
      is_skip   = 1'b0;
      is_branch = 1'b0;
      unique case (req.op)
         skip_on_equal_op: begin
            is_skip = 1'b1;
            cond    = (left == right);
         end
         branch_on_equal_op: begin
            is_branch = 1'b1;
            cond      = (left == right);
         end
         skip_on_greater_op: begin
            is_skip = 1'b1;
            cond    = ($signed(left) > $signed(right));
         end
         branch_on_greater_op: begin
            is_branch = 1'b1;
            cond      = ($signed(left) > $signed(right));
         end
         skip_on_less_op: begin
            is_skip = 1'b1;
            cond    = ($signed(left) < $signed(right));
         end
         branch_on_less_op: begin
            is_branch = 1'b1;
            cond      = ($signed(left) < $signed(right));
         end
         skip_on_unequal_op: begin
            is_skip = 1'b1;
            cond    = (left != right);
         end
         branch_on_unequal_op: begin
            is_branch = 1'b1;
            cond      = (left != right);
         end
         default: begin
            cond = 1'b0;
         end
      endcase
   end

   // Decision and cycle cost for the pipeline.
   always_comb begin
      next_result             = '0;
      next_result.cycles      = BASE_CYCLES;
      next_result.flags       = sub_flags;
      if (req.valid && req.op != idle_op) begin
         if (req.op == compare_op || req.op == compare_zero_op
             || req.op == compare_borrow_op) begin
            next_result.flags_write = 1'b1;
         end
         if (is_skip && cond) begin
            next_result.skip   = 1'b1;
            next_result.cycles = skip_cost(req.next_is_two_word);
         end
         if (is_branch && cond) begin
            next_result.branch = 1'b1;
            next_result.cycles = TAKEN_CYCLES;
         end
         // Only compares (plain, zero and borrow) read file locations, so only they can pay the peripheral toll.
         if (req.peripheral_operand && sfr_penalty_en && !is_skip && !is_branch) begin
            next_result.cycles = next_result.cycles + SFR_EXTRA;
         end
      end else begin
         next_result.flags = '0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         result <= '0;
      end else begin
         result <= next_result;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         last_flags <= '0;
      end else if (next_result.flags_write) begin
         last_flags <= next_result.flags;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         op_count <= 16'h0000;
      end else if (req.valid && req.op != idle_op) begin
         op_count <= op_count + 16'h0001;
      end
   end

   // Wishbone slave: one registered ack per request, a cycle after the strobe, dropped in the following cycle.
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   // Control writes commit on the edge where the master sees ack, so a master that drops
   // its request before the answer leaves the control bit untouched.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sfr_penalty_en <= 1'b1;
      end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
                   && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
         sfr_penalty_en <= wb_dat_i[CTRL_SFR_EN_BIT];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wb_dat_o <= READ_ZERO;
      end else if (wb_hit && !wb_we_i) begin
         unique case (wb_adr_i)
            ADDR_CTRL:   wb_dat_o <= {31'h0000_0000, sfr_penalty_en};
            ADDR_STATUS: wb_dat_o <= {27'h000_0000, last_flags};
            ADDR_COUNT:  wb_dat_o <= {16'h0000, op_count};
            default:     wb_dat_o <= READ_ZERO;
         endcase
      end
   end
endmodule

// ==== verification/csb_properties.sv ====
// Port checker for the compare unit.
`timescale 1ns/1ps
module csb_properties
   import compare_unit_pkg::*;
(
   input wire logic   mclk,      // Clock.
   input wire logic   rst,       // Reset.
   input request_type req,       // Request.
   input wire logic   carry_now, // Carry.
   input result_type  result,    // Decision.
   input wire logic   wb_cyc_i,  // Cycle.
   input wire logic   wb_stb_i,  // Strobe.
   input wire logic   wb_ack_o   // Ack.
);
   wire logic same = req.base_operand_reg == req.source_operand_reg;
   wire logic less = $signed(req.base_operand_reg) < $signed(req.source_operand_reg);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   a_idle_quiet: assert property (!req.valid |=> result == 12'h001) else $error("idle");
   a_cmp_zero: assert property (req.valid && req.op == compare_op &&
      req.source == src_register |=> result.flags.zero == $past(same)) else $error("zero");
   a_zero_carry: assert property (req.valid && req.op == compare_zero_op |=>
      result.flags.carry && !result.flags.signed_wrap_flag) else $error("zero cmp");
   a_borrow_in: assert property (req.valid && req.op == compare_borrow_op && same &&
      req.source == src_register && !carry_now |=> result.flags.negative && !result.flags.carry)
      else $error("borrow");
   a_skip_equal: assert property (req.valid && req.op == skip_on_equal_op && same &&
      !req.next_is_two_word |=> result.skip && result.cycles == SKIP1_CYCLES) else $error("seq");
   a_branch_cost: assert property (result.branch |->
      result.cycles == TAKEN_CYCLES && !result.flags_write) else $error("branch");
   a_less_skip: assert property (req.valid && req.op == skip_on_less_op && less |=>
      result.skip && !result.flags_write) else $error("less");
   a_two_word: assert property (req.valid && req.next_is_two_word ##1 result.skip |->
      result.cycles == SKIP2_CYCLES) else $error("two word");
endmodule
bind compare_skip_branch_unit csb_properties chk_u (.mclk, .rst, .req, .carry_now, .result,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ==== verification/pipe_model.sv ====
// Pipeline model that issues one decoded request and collects the decision.
`timescale 1ns/1ps
module pipe_model
   import compare_unit_pkg::*;
(
   input  wire logic   mclk,      // Clock.
   output request_type req,       // Request.
   output logic        carry_now, // Core carry.
   input  result_type  result     // Decision.
);
   initial begin
      req = '0;
      carry_now = 1'b0;
   end
   // Released operands are inverted so a stale value never passes for a live one.
   task automatic issue(request_type r, logic c, output result_type res);
      request_type gone;
      gone = request_type'(~r);
      gone.valid = 1'b0;
      @(posedge mclk);
      req <= r;
      carry_now <= c;
      @(posedge mclk);
      req <= gone;
      carry_now <= ~c;
      @(negedge mclk);
      res = result;
   endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking testbench for the compare, skip and branch unit.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
   import compare_unit_pkg::*;
   logic        mclk, rst, carry_now, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, t;
   logic [3:0]  wb_adr_i, wb_sel_i, n;
   logic [6:0]  ex;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [15:0] pa [3] = '{16'hFFFF, 16'h0003, 16'h0001};
   logic [15:0] pb [3] = '{16'h0001, 16'h0003, 16'hFFFF};
   request_type req;
   result_type  result, res;
   int          errors, checked, ticks;
   compare_skip_branch_unit dut_u (.mclk, .rst, .req, .carry_now, .result, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   pipe_model pipe_u (.mclk, .req, .carry_now, .result);
   function automatic request_type mk(op_type o, source_type s, logic [15:0] a, b, logic p, w);
      return '{1'b1, o, s, a, b, b, b[7:0], p, w};
   endfunction
   task automatic cmp(op_type o, source_type s, logic [15:0] a, b, logic c, p,
                      logic [4:0] f, logic [3:0] k);
      pipe_u.issue(mk(o, s, a, b, p, 1'b0), c, res);
      `CHK(res, {1'b1, f, 2'h0, k})
   endtask
   task automatic wb(logic we, logic [3:0] a, logic [31:0] d, logic [3:0] s);
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic stop_test();
      $display("Checks %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      ticks++;
      if (ticks == 2000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      repeat (20) @(posedge mclk);
      `CHK(result, 12'h000)
      rst <= 1'b0;
      wb(1'b0, ADDR_CTRL, 32'h0000_0000, 4'hF);
      `CHK(rd, 32'h0000_0001)
      cmp(compare_op, src_register, 16'h0005, 16'h0007, 1'b1, 1'b0, 5'h04, 4'h1);
      cmp(compare_op, src_register, 16'h0003, 16'h0003, 1'b1, 1'b0, 5'h19, 4'h1);
      cmp(compare_zero_op, src_register, 16'h8000, 16'h8000, 1'b1, 1'b0, 5'h1C, 4'h1);
      cmp(compare_borrow_op, src_accumulator, 16'h000F, 16'h000F, 1'b0, 1'b0, 5'h04, 4'h1);
      cmp(compare_borrow_op, src_literal, 16'h0100, 16'h0100, 1'b0, 1'b0, 5'h10, 4'h1);
      cmp(compare_borrow_op, src_register, 16'h1234, 16'h1234, 1'b0, 1'b0, 5'h04, 4'h1);
      cmp(compare_borrow_op, src_register, 16'h1234, 16'h1234, 1'b1, 1'b0, 5'h19, 4'h1);
      cmp(compare_borrow_op, src_register, 16'h8000, 16'h0000, 1'b0, 1'b0, 5'h12, 4'h1);
      wb(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hF);
      `CHK(rd, 32'h0000_0012)
      cmp(compare_op, src_register, 16'h0005, 16'h0007, 1'b1, 1'b1, 5'h04, 4'h2);
      wb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'h0);
      wb(1'b0, ADDR_CTRL, 32'h0000_0000, 4'hF);
      `CHK(rd, 32'h0000_0001)
      wb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'hF);
      wb(1'b0, ADDR_CTRL, 32'h0000_0000, 4'hF);
      `CHK(rd, 32'h0000_0000)
      cmp(compare_op, src_register, 16'h0003, 16'h0003, 1'b1, 1'b1, 5'h19, 4'h1);
      wb(1'b0, 4'hC, 32'h0000_0000, 4'hF);
      `CHK(rd, READ_ZERO)
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j < 3; j++) begin
            pipe_u.issue(mk(op_type'(i + 3), src_register, pa[j], pb[j], 1'b0, !j[0]),
                         1'b1, res);
            case (i / 2)
               0: t = pa[j] == pb[j];
               1: t = $signed(pa[j]) > $signed(pb[j]);
               2: t = $signed(pa[j]) < $signed(pb[j]);
               default: t = pa[j] != pb[j];
            endcase
            n = !t ? BASE_CYCLES : i[0] ? TAKEN_CYCLES : j[0] ? SKIP1_CYCLES : SKIP2_CYCLES;
            ex = {1'b0, t & !i[0], t & i[0], n};
            `CHK({res[11], res[5:0]}, ex)
         end
      end
      wb(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hF);
      `CHK(rd, 32'h0000_0019)
      wb(1'b0, ADDR_COUNT, 32'h0000_0000, 4'hF);
      `CHK(rd, 32'h0000_0022)
      stop_test();
   end
endmodule
